// [rtl/hfmon_pkg.sv]
// Constants and types shared by the HF gain and bit recovery monitor.
package hfmon_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned UP_TC_US = 1000;
	localparam int unsigned DOWN_TC_US = 60;
	localparam int unsigned UP_TC_CYC = UP_TC_US * CLK_MHZ;
	localparam int unsigned DOWN_TC_CYC = DOWN_TC_US * CLK_MHZ;
	localparam int unsigned AGC_WIN = 128;
	localparam int unsigned CLIP_PCT = 20;
	localparam logic [7:0] IDX_ANA = 8'h15;
	localparam logic [7:0] IDX_DET = 8'h16;
	localparam logic [7:0] IDX_STAT = 8'h17;
	localparam logic [7:0] IDX_MEAS = 8'h18;
	localparam int unsigned AG_AUTO_BIT = 7;
	localparam int unsigned AG_CEIL_BIT = 6;
	localparam int unsigned AG_UP_BIT = 5;
	localparam int unsigned AG_DN_BIT = 4;
	localparam int unsigned AG_PD_BIT = 3;
	localparam int unsigned DET_ADV_BIT = 0;
	localparam int unsigned DET_SL2_BIT = 1;
	localparam int unsigned DET_N_LSB = 4;
	localparam logic [7:0] DET_RST = 8'h10;
	localparam logic [4:0] GAIN_RST = 5'h08;
	localparam logic [4:0] GAIN_MAX = 5'h1f;
	localparam logic [4:0] GAIN_CAP = 5'h16;
	localparam int unsigned JIT_SQ_SHIFT = 7;
	localparam int unsigned BIT_CLKS = 4;
	localparam int unsigned FRAME_BITS = 64;
	localparam int unsigned PAUSE_POS = 47;
	localparam logic [63:0] FRAME_MARKS = 64'h0000_0004_0100_1001;
	localparam logic [7:0] INNER_RANGE = 8'h0c;
	localparam logic [7:0] LOCK_TOL = 8'h02;
	localparam logic [3:0] LONG_RUN = 4'he;
	typedef enum {LK_OUTER, LK_INNER, LK_LOCKED} hfmon_lock_e;
	typedef enum {AG_HOLD, AG_UP, AG_DOWN} hfmon_agc_e;
endpackage

// [rtl/hfmon_top.sv]
// HF gain control, bit recovery observation and measurement pin.
// Function
// - Extreme ADC codes lower gain, none raise.
// - Gain spans 14 dB in 32 steps.
// - Write with bit 5 raises gain one step.
// - Write with bit 4 lowers gain one step.
// - Steps past either gain limit are ignored.
// - Auto mode raises gain, 1000/n us constant.
// - Auto mode holds gain at full scale.
// - Clipping over 20% lowers gain, 60/n us.
// - Bit 7 selects hold or automatic gain.
// - Bit 6 caps gain at 7.66 dB.
// - Bit 3 powers analog blocks down.
// - Noise filter runs on bit clock.
// - Advanced detector pushes run 2 to 3.
// - Switchable faster second slicer stage.
// - Inner and outer lock aids pull PLL.
// - Jitter is averaged squared error, readable.
// - Asymmetry readable as signed byte.
// - Inner-lock, lock and run-14 flags readable.
// - 64-bit frames, 4 clocks per bit.
// - Frame carries markers, jitter, frequency, asymmetry.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
module hfmon_top
	import hfmon_pkg::*;
#(
	parameter int unsigned UP_CYC = UP_TC_CYC,
	parameter int unsigned DN_CYC = DOWN_TC_CYC,
	parameter int unsigned WIN = AGC_WIN
)
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// AHB-Lite slave.
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// ADC samples and bit recovery observations.
	input wire logic [7:0] adc_data_i,
	input wire logic bit_clk_en_i,
	input wire logic trans_valid_i,
	input wire logic [1:0] trans_err_i,
	input wire logic [9:0] pll_freq_i,
	input wire logic signed [7:0] freq_err_i,
	// Front-end controls and detector outputs.
	output logic [4:0] vga_gain_o,
	output logic analog_power_off_o,
	output logic det_bit_o,
	output logic outer_aid_o,
	output logic inner_aid_o,
	output logic measurement_serial_pin_o
);

	if (WIN < 2 || WIN > 255 || UP_CYC < 16 || DN_CYC < 16 || UP_CYC > 24'hfff000
		|| DN_CYC > 24'hfff000)
	begin : g_chk
		$error("hfmon_top: parameter out of range");
	end

	// Bus decode: one word per register, index times four is the byte address.
	wire logic [7:0] a_idx = haddr_i[9:2];
	wire logic a_hit = hsel_i && htrans_i[1] && hready_i && hsize_i == 3'h2
		&& haddr_i[31:10] == 22'h0;
	wire logic a_wr = a_hit && hwrite_i;
	wire logic a_rd = a_hit && !hwrite_i;
	logic wr_pend;
	logic [7:0] wr_idx;
	wire logic ana_wr = wr_pend && wr_idx == IDX_ANA;
	wire logic det_wr = wr_pend && wr_idx == IDX_DET;
	wire logic stat_rd = a_rd && a_idx == IDX_STAT;

	logic auto_on;
	logic ceil_on;
	logic [7:0] det_q;
	logic long_flag;
	logic [9:0] jit;
	logic signed [10:0] lvl1;
	hfmon_lock_e lk;
	hfmon_lock_e next_lk;
	wire logic inner_flag = lk != LK_OUTER;
	wire logic lock_flag = lk == LK_LOCKED;
	wire logic [7:0] asym = lvl1[10:3];

	wire logic [31:0] rd_mux =
		(a_idx == IDX_STAT) ? {21'h0, long_flag, lock_flag, inner_flag, 3'h0, vga_gain_o} :
		(a_idx == IDX_MEAS) ? {8'h0, pll_freq_i[9:2], asym, jit[9:2]} :
		(a_idx == IDX_DET) ? {24'h0, det_q} : 32'h0;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_pend <= 1'b0;
			wr_idx <= 8'h00;
			hrdata_o <= 32'h0;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
		else
		begin
			wr_pend <= a_wr;
			wr_idx <= a_idx;
			hrdata_o <= a_rd ? rd_mux : 32'h0;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	// Control registers; the gain step bits act on write and are not stored.
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			auto_on <= 1'b0;
			ceil_on <= 1'b0;
			analog_power_off_o <= 1'b0;
			det_q <= DET_RST;
		end
		else
		begin
			if (ana_wr)
			begin
				auto_on <= hwdata_i[AG_AUTO_BIT];
				ceil_on <= hwdata_i[AG_CEIL_BIT];
				analog_power_off_o <= hwdata_i[AG_PD_BIT];
			end
			if (det_wr)
				det_q <= hwdata_i[7:0];
		end
	end

	// Clip statistics over a window of ADC samples decide the regulation direction.
	logic [7:0] win_cnt;
	logic [7:0] clip_cnt;
	hfmon_agc_e agc_dir;
	hfmon_agc_e new_dir;
	wire logic clip_now = adc_data_i == 8'h00 || adc_data_i == 8'hff;
	wire logic win_end = win_cnt == 8'(WIN - 1);
	wire logic [7:0] clip_tot = clip_cnt + {7'h0, clip_now};
	wire logic over = {8'h0, clip_tot} * 16'd100 > 16'(CLIP_PCT * WIN);

	always_comb
	begin
		if (over)
			new_dir = AG_DOWN;
		else if (clip_tot == 8'h00)
			new_dir = AG_UP;
		else
			new_dir = AG_HOLD;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			win_cnt <= 8'h00;
			clip_cnt <= 8'h00;
			agc_dir <= AG_HOLD;
		end
		else
		begin
			win_cnt <= win_end ? 8'h00 : win_cnt + 8'h01;
			clip_cnt <= win_end ? 8'h00 : clip_tot;
			if (win_end)
				agc_dir <= new_dir;
		end
	end

	// Step timer adds the speed factor each cycle, dividing the time constant by n.
	logic [23:0] tc_acc;
	wire logic [3:0] n_raw = det_q[DET_N_LSB +: 4];
	wire logic [3:0] n_eff = (n_raw == 4'h0) ? 4'h1 : n_raw;
	wire logic [23:0] acc_nx = tc_acc + {20'h0, n_eff};
	wire logic auto_up = auto_on && agc_dir == AG_UP && acc_nx >= 24'(UP_CYC);
	wire logic auto_dn = auto_on && agc_dir == AG_DOWN && acc_nx >= 24'(DN_CYC);
	wire logic tc_clr = !auto_on || agc_dir == AG_HOLD || auto_up || auto_dn
		|| (win_end && new_dir != agc_dir);

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			tc_acc <= 24'h0;
		else
			tc_acc <= tc_clr ? 24'h0 : acc_nx;
	end

	// Gain index 0 is the bottom limit; a write that asks for both steps is ignored.
	logic [4:0] next_gain;
	wire logic up_req = ana_wr && hwdata_i[AG_UP_BIT] && !hwdata_i[AG_DN_BIT];
	wire logic dn_req = ana_wr && hwdata_i[AG_DN_BIT] && !hwdata_i[AG_UP_BIT];
	wire logic [4:0] gain_top = ceil_on ? GAIN_CAP : GAIN_MAX;
	wire logic can_up = vga_gain_o < gain_top;
	wire logic can_dn = vga_gain_o != 5'h00;
	wire logic ceil_over = ceil_on && vga_gain_o > GAIN_CAP;

	always_comb
	begin
		next_gain = vga_gain_o;
		if (ceil_over)
			next_gain = GAIN_CAP;
		else if (up_req && can_up)
			next_gain = vga_gain_o + 5'h01;
		else if (dn_req && can_dn)
			next_gain = vga_gain_o - 5'h01;
		else if (!ana_wr && auto_up && can_up)
			next_gain = vga_gain_o + 5'h01;
		else if (!ana_wr && auto_dn && can_dn)
			next_gain = vga_gain_o - 5'h01;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			vga_gain_o <= GAIN_RST;
		else
			vga_gain_o <= next_gain;
	end

	// Noise filter: 1-2-2-1 taps at the bit rate, notch toward half the bit rate.
	logic [2:0][7:0] taps;
	logic signed [10:0] filt;
	wire logic signed [7:0] x_in = adc_data_i ^ 8'h80;
	wire logic signed [10:0] f_sum = 11'(x_in) + 11'($signed(taps[0]) * 2)
		+ 11'($signed(taps[1]) * 2) + 11'($signed(taps[2]));

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			taps <= '0;
			filt <= 11'sh0;
		end
		else if (bit_clk_en_i)
		begin
			taps <= {taps[1:0], x_in};
			filt <= f_sum;
		end
	end

	// Slow slice level tracks asymmetry; the fast one forms the adaptive stage.
	logic signed [10:0] lvl2;
	wire logic signed [11:0] d1 = 12'(filt) - 12'(lvl1);
	wire logic signed [11:0] d2 = 12'(filt) - 12'(lvl2);
	wire logic sl2_on = det_q[DET_SL2_BIT];
	wire logic signed [11:0] d_ref = sl2_on ? d2 : d1;
	wire logic dec = !d_ref[11] && d_ref != 12'sh0;
	wire logic [10:0] mag = d_ref[11] ? 11'(-d_ref) : 11'(d_ref);

	// Run-length 2 push-back moves the edge that sits closer to the slice level.
	logic [3:0] sr;
	logic [3:0][10:0] mg;
	logic [3:0] fx;
	logic [3:0] run;
	wire logic adv_on = det_q[DET_ADV_BIT];
	wire logic hit = sr[0] != sr[1] && sr[1] == sr[2] && sr[2] != sr[3];
	wire logic same = fx[3] == det_bit_o;
	wire logic long_hit = bit_clk_en_i && same && run >= LONG_RUN - 4'h1;

	always_comb
	begin
		fx = sr;
		if (adv_on && hit)
		begin
			if (mg[0] < mg[3])
				fx[0] = sr[1];
			else
				fx[3] = sr[2];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lvl1 <= 11'sh0;
			lvl2 <= 11'sh0;
			sr <= 4'h0;
			mg <= '0;
			det_bit_o <= 1'b0;
			run <= 4'h1;
		end
		else if (bit_clk_en_i)
		begin
			lvl1 <= lvl1 + 11'(d1 >>> 6);
			lvl2 <= lvl2 + 11'(d2 >>> 2);
			sr <= {fx[2:0], dec};
			mg <= {mg[2:0], mag};
			det_bit_o <= fx[3];
			run <= same ? ((run == 4'hf) ? run : run + 4'h1) : 4'h1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			long_flag <= 1'b0;
		else
			long_flag <= long_hit || (long_flag && !stat_rd);
	end

	// Error arrives in eighths of a bit, so the square times 8192 is e*e shifted by 7.
	wire logic [3:0] e2 = {2'b0, trans_err_i} * {2'b0, trans_err_i};
	wire logic [10:0] sq = {e2, 7'h0} >> (7 - JIT_SQ_SHIFT);
	wire logic [9:0] jsq = sq[10] ? 10'h3ff : sq[9:0];
	wire logic signed [11:0] jd = $signed({2'b0, jsq}) - $signed({2'b0, jit});
	wire logic [11:0] jn = {2'b0, jit} + 12'(jd >>> 4);

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			jit <= 10'h0;
		else if (trans_valid_i)
			jit <= jn[9:0];
	end

	// Lock aids: outer aid until within the inner range, inner aid until locked.
	wire logic [7:0] ferr_abs = freq_err_i[7] ? 8'(-freq_err_i) : freq_err_i;

	always_comb
	begin
		case (lk)
			LK_OUTER:
				next_lk = (ferr_abs <= INNER_RANGE) ? LK_INNER : LK_OUTER;
			LK_INNER:
				if (ferr_abs > INNER_RANGE)
					next_lk = LK_OUTER;
				else
					next_lk = (ferr_abs <= LOCK_TOL) ? LK_LOCKED : LK_INNER;
			LK_LOCKED:
				next_lk = (ferr_abs > INNER_RANGE) ? LK_OUTER : LK_LOCKED;
			default:
				next_lk = LK_OUTER;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lk <= LK_OUTER;
			outer_aid_o <= 1'b0;
			inner_aid_o <= 1'b0;
		end
		else
		begin
			lk <= next_lk;
			outer_aid_o <= next_lk == LK_OUTER;
			inner_aid_o <= next_lk == LK_INNER;
		end
	end

	// Measurement frame, captured at the end of the previous frame.
	logic [5:0] mbit;
	logic [1:0] mph;
	logic [63:0] mframe;
	wire logic [63:0] frame_nx = {17'h0, jit, 2'b00, 1'b1, 1'b0, asym, 1'b1, 1'b0,
		pll_freq_i, 1'b1, 1'b0, jit, 1'b1};
	wire logic bit_end = mph == 2'(BIT_CLKS - 1);
	wire logic fr_end = bit_end && mbit == 6'(FRAME_BITS - 1);

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mph <= 2'h0;
			mbit <= 6'h0;
			mframe <= FRAME_MARKS;
			measurement_serial_pin_o <= 1'b0;
		end
		else
		begin
			mph <= mph + 2'h1;
			if (bit_end)
				mbit <= mbit + 6'h1;
			if (fr_end)
				mframe <= frame_nx;
			measurement_serial_pin_o <= mframe[mbit];
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_frame_start;
		mbit == 6'h0 && mph == 2'h0;
	endsequence
	sequence s_start_bit;
		measurement_serial_pin_o [*4];
	endsequence
	sequence s_manual_up;
		up_req && can_up && !ceil_over;
	endsequence

	AST_FRAME_START: assert property (s_frame_start |=> s_start_bit)
		else $error("start bit not sent for four clocks");
	AST_PAUSE: assert property (mbit >= 6'(PAUSE_POS) |=> !measurement_serial_pin_o)
		else $error("pause bit not zero");
	AST_GAP: assert property ((mbit == 6'd35 || mbit == 6'd36) |=> !measurement_serial_pin_o)
		else $error("frame bit 35 or 36 not zero");
	AST_UP_STEP: assert property (s_manual_up |=> vga_gain_o == $past(vga_gain_o) + 5'h01)
		else $error("manual step up missing");
	AST_DN_FLOOR: assert property (vga_gain_o == 5'h00 && dn_req |=> vga_gain_o == 5'h00)
		else $error("gain stepped below floor");
	AST_CEIL: assert property (ceil_on |=> vga_gain_o <= GAIN_CAP)
		else $error("gain above ceiling");
	AST_HOLD: assert property (!auto_on && !ana_wr && !ceil_over |=> $stable(vga_gain_o))
		else $error("gain moved in hold");
	AST_AUTO_UP: assert property (auto_up && !ana_wr && can_up && !ceil_over
		|=> vga_gain_o == $past(vga_gain_o) + 5'h01)
		else $error("automatic step up missing");
	AST_CLIP_DN: assert property (win_end && over |=> agc_dir == AG_DOWN)
		else $error("clipping did not select step down");
	AST_RL2: assert property (bit_clk_en_i && adv_on && hit
		|=> sr[2] == sr[1] || det_bit_o == sr[3])
		else $error("run length 2 not pushed back");
	AST_INNER: assert property (lk == LK_OUTER && ferr_abs <= INNER_RANGE |=> inner_aid_o)
		else $error("inner aid not entered");
	AST_JIT_RD: assert property (a_rd && a_idx == IDX_MEAS
		|=> hrdata_o[7:0] == $past(jit[9:2]))
		else $error("jitter read wrong");
	AST_PD: assert property (ana_wr |=> analog_power_off_o == $past(hwdata_i[AG_PD_BIT]))
		else $error("power down not taken");
endmodule

// [verification/hfmon_preamp_model.sv]
// Preamplifier and bit clock model feeding the monitor's sample inputs.
`timescale 1ns/1ns
module hfmon_preamp_model
(
	// Clock, reset and signal shape.
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] mode_i,
	// Samples and bit recovery pulses.
	output logic [7:0] adc_o,
	output logic bit_en_o,
	output logic trans_valid_o,
	output logic [1:0] trans_err_o
);
	logic [7:0] ph;
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ph <= 8'h00;
			adc_o <= 8'h80;
			bit_en_o <= 1'b0;
			trans_valid_o <= 1'b0;
			trans_err_o <= 2'h0;
		end
		else
		begin
			ph <= ph + 8'h01;
			// Half the system clock keeps the channel rate inside its bounds.
			bit_en_o <= ph[0];
			trans_valid_o <= (ph[2:0] == 3'h7);
			trans_err_o <= 2'h1;
			// Mode 0 never clips, mode 1 clips always, mode 2 touches full scale rarely.
			case (mode_i)
				2'h1: adc_o <= ph[0] ? 8'hff : 8'h00;
				2'h2: adc_o <= (ph[3:0] == 4'hf) ? 8'hff : {2'b01, ph[5:0]};
				default: adc_o <= {2'b01, ph[5:0]};
			endcase
		end
	end
endmodule

// [verification/hf_gain_and_bit_recovery_monitor_tb.sv]
// Self-checking testbench of the HF gain and bit recovery monitor.
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module hf_gain_and_bit_recovery_monitor_tb;
	import hfmon_pkg::*;
	typedef struct packed {logic [7:0] wd; logic [4:0] g; logic p;} hfmon_row_s;
	localparam logic [31:0] ANA = 32'h54;
	localparam logic [31:0] DET = 32'h58;
	localparam logic [31:0] STAT = 32'h5c;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] mode = 2'h0;
	logic [9:0] pll_f = 10'h000;
	logic signed [7:0] ferr = 8'h32;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic [7:0] adc;
	logic bit_en;
	logic tv;
	logic [1:0] te;
	logic [4:0] gain;
	logic pwr;
	logic outer;
	logic inner;
	logic pin;
	int bad_count = 0;
	int checks_done = 0;
	logic [31:0] r;
	logic [63:0] fr;
	logic [63:0] e;
	logic [63:0] m;
	int z;
	hfmon_row_s rows [7] = '{'{8'h20, 5'h09, 1'b0}, '{8'h20, 5'h0a, 1'b0},
		'{8'h10, 5'h09, 1'b0}, '{8'h30, 5'h09, 1'b0}, '{8'h00, 5'h09, 1'b0},
		'{8'h08, 5'h09, 1'b1}, '{8'h00, 5'h09, 1'b0}};
	hfmon_top #(.UP_CYC(64), .DN_CYC(16), .WIN(32)) hfmon_top_inst (.sys_clk_i(clk),
		.rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .adc_data_i(adc),
		.bit_clk_en_i(bit_en), .trans_valid_i(tv), .trans_err_i(te), .pll_freq_i(pll_f),
		.freq_err_i(ferr), .vga_gain_o(gain), .analog_power_off_o(pwr), .det_bit_o(),
		.outer_aid_o(outer), .inner_aid_o(inner), .measurement_serial_pin_o(pin));
	hfmon_preamp_model hfmon_preamp_model_inst (.clk_i(clk), .rst_n_i(rst_n),
		.mode_i(mode), .adc_o(adc), .bit_en_o(bit_en), .trans_valid_o(tv),
		.trans_err_o(te));
	initial
	begin
		forever #5 clk = ~clk;
	end
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr_wait(input logic [31:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h0, d});
		@(posedge clk);
		#1;
	endtask
	task automatic end_sim;
		if (bad_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (30000) @(posedge clk);
		bad_count++;
		end_sim();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		`CHK(gain, GAIN_RST)
		`CHK(pwr, 1'b0)
		xfer(1'b0, DET, 32'h0);
		`CHK(r, 32'h10)
		xfer(1'b0, ANA, 32'h0);
		`CHK(r, 32'h0)
		xfer(1'b0, 32'h400, 32'h0);
		`CHK({hresp, r}, 33'h0)
		wr_wait(32'h454, 8'h20);
		`CHK(gain, 5'h08)
		`CHK(outer, 1'b1)
		foreach (rows[i])
		begin
			wr_wait(ANA, rows[i].wd);
			`CHK(gain, rows[i].g)
			`CHK(pwr, rows[i].p)
			xfer(1'b0, STAT, 32'h0);
			`CHK(r[4:0], rows[i].g)
		end
		repeat (30) wr_wait(ANA, 8'h20);
		`CHK(gain, 5'h1f)
		wr_wait(ANA, 8'h40);
		`CHK(gain, 5'h16)
		wr_wait(ANA, 8'h60);
		`CHK(gain, 5'h16)
		repeat (30) wr_wait(ANA, 8'h10);
		`CHK(gain, 5'h00)
		// Speed factor 4 must finish the climb well before a factor of 1 could.
		wr_wait(DET, 8'h40);
		wr_wait(ANA, 8'h80);
		repeat (700) @(posedge clk);
		#1;
		`CHK(gain, 5'h1f)
		@(posedge clk);
		mode <= 2'h1;
		repeat (1000) @(posedge clk);
		#1;
		`CHK(gain, 5'h00)
		@(posedge clk);
		mode <= 2'h2;
		wr_wait(DET, 8'h43);
		xfer(1'b0, DET, 32'h0);
		`CHK(r, 32'h43)
		repeat (100) @(posedge clk);
		// Lift the gain off the floor so that a wrong direction would show.
		repeat (5) wr_wait(ANA, 8'ha0);
		repeat (1000) @(posedge clk);
		#1;
		`CHK(gain, 5'h05)
		wr_wait(ANA, 8'h00);
		mode <= 2'h0;
		pll_f <= 10'h2a5;
		repeat (600) @(posedge clk);
		z = 0;
		while (1)
		begin
			@(posedge clk);
			#1;
			if (pin === 1'b1 && z >= 68)
				break;
			z = (pin === 1'b0) ? z + 1 : 0;
		end
		fr = 64'h1;
		for (int k = 1; k < 64; k++)
		begin
			repeat (4) @(posedge clk);
			#1;
			fr[k] = pin;
		end
		// Jitter and asymmetry fields carry measured data and are masked out.
		m = '1;
		m[10:1] = '0;
		m[32:25] = '0;
		m[46:37] = '0;
		e = '0;
		e[0] = 1'b1;
		e[12] = 1'b1;
		e[24] = 1'b1;
		e[34] = 1'b1;
		e[22:13] = 10'h2a5;
		`CHK(fr & m, e)
		`CHK(fr[46:37], fr[10:1])
		xfer(1'b0, 32'h60, 32'h0);
		`CHK({r[23:16], r[7:0]}, {8'ha9, fr[10:3]})
		ferr <= 8'hf8;
		repeat (10) @(posedge clk);
		#1;
		`CHK({inner, outer}, 2'b10)
		ferr <= 8'h00;
		repeat (300) @(posedge clk);
		xfer(1'b0, STAT, 32'h0);
		`CHK({r[9:8], inner, outer}, 4'b1100)
		ferr <= 8'h32;
		repeat (100) @(posedge clk);
		#1;
		`CHK(outer, 1'b1)
		// A second reset in mid-run must act at once and restart cleanly.
		rst_n <= 1'b0;
		#1;
		`CHK({gain, outer, pwr, pin}, 8'h40)
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK({outer, gain}, 6'h28)
		end_sim();
	end
endmodule
